//--- verilog/math_cfg.svh
// Purpose: constants for the saturating math blocks
// Assumes: 16-bit signed words, 32-bit running sum
// Notes: definitions only, no logic
//
// What this block does
// - adder adds two signed words; above +32767 clamps there and flags overflow
// - adder sum below -32768 clamps to -32768 and flags overflow
// - accumulator adds input to running sum each enabled step, wrapping freely
// - accumulator output is running-sum field from low to high position
// - unused upper output bits of a narrow accumulator field read zero
// - enable low: accumulator loads preset into the running sum and outputs preset plus input
// - accumulator ports: signed input, 5-bit positions, preset, unsigned output
// - counter clear forces output to zero regardless of enable
// - enabled counter adds input to previous output, saturating to 16 bits
// - counter not cleared and disabled holds its output
// - counter at positive limit stays there under non-negative input, never wraps
// - shifter scales input by two to a signed exponent from -15 to 15
// - negative exponent gives arithmetic right shift keeping the sign
// - multiplier forms 32-bit product, signed or unsigned by selector
// - product not fitting high-plus-one bits clamps to largest such value
// - signed product below most negative N-bit value clamps to it
// - multiplier outputs high-to-low field, sign-extended to 16 bits when signed, zero-filled when unsigned
`ifndef MATH_CFG_SVH
`define MATH_CFG_SVH
`define WORD_WIDTH 16
`define SUM_WIDTH 32
`define POS_WIDTH 5
`define POS_LIMIT 16'sh7fff
`define NEG_LIMIT 16'sh8000
`define RESET_WORD 16'h0000
`define RESET_SUM 32'h0000_0000
`define FIELD_FULL 6'h10
`define FIELD_ONE 6'h01
`define MUL_SIGNED_DEFAULT 1'b1
`define MUL_HIGH_DEFAULT 5'h0e
`define MUL_LOW_DEFAULT 5'h05
`endif

//--- verilog/math_pkg.sv
// Purpose: shared types of the saturating math blocks
// Assumes: math_cfg.svh gives the widths
// Notes: types only
`include "math_cfg.svh"
package math_pkg;
    typedef logic signed [`WORD_WIDTH-1:0] sword_t;
    typedef logic [`WORD_WIDTH-1:0] uword_t;
    typedef logic [`POS_WIDTH-1:0] bitpos_t;
    typedef logic signed [`POS_WIDTH-1:0] exp_t;
    typedef logic [`SUM_WIDTH-1:0] runsum_t;
endpackage : math_pkg

//--- verilog/multiply_extract.sv
// Purpose: multiplier with saturation and field extraction
// Assumes: selector and positions fixed at build time
// Notes: purely combinational; the caller registers the result
`timescale 1ns/10ps
`default_nettype none
`include "math_cfg.svh"
module multiply_extract #(
    parameter bit SIGNED_MODE = `MUL_SIGNED_DEFAULT,
    parameter math_pkg::bitpos_t HIGH_POS = `MUL_HIGH_DEFAULT,
    parameter math_pkg::bitpos_t LOW_POS = `MUL_LOW_DEFAULT
) (
    input wire math_pkg::sword_t operand_a,
    input wire math_pkg::sword_t operand_b,
    output math_pkg::uword_t field
);
    import math_pkg::*;

    localparam int N = int'(HIGH_POS) + 1;
    localparam int SPAN = int'(HIGH_POS) - int'(LOW_POS) + 1;

    // a bad span stops the build instead of giving a silent wrong field
    generate
        if (SPAN < 1 || SPAN > `WORD_WIDTH) begin : g_bad_span
            $error("multiply_extract: field span out of range");
        end
    endgenerate

    // 34 bits hold both the signed and the unsigned product with room to compare
    localparam logic signed [33:0] S_MAX = (34'sd1 <<< (N - 1)) - 34'sd1;
    localparam logic signed [33:0] S_MIN = -(34'sd1 <<< (N - 1));
    localparam logic signed [33:0] U_MAX = (34'sd1 <<< N) - 34'sd1;
    localparam uword_t LOW_MASK = 16'((17'h1 << SPAN) - 17'h1);

    wire logic signed [33:0] prod_s;
    wire logic signed [33:0] prod_u;
    wire logic signed [33:0] prod;
    wire logic signed [33:0] limit_hi;
    wire logic over;
    wire logic under;
    wire logic signed [33:0] clamped;
    wire logic signed [33:0] shifted;
    wire logic fill;

    assign prod_s = 34'(operand_a) * 34'(operand_b);
    assign prod_u = $signed({18'h0, operand_a}) * $signed({18'h0, operand_b});
    assign prod = SIGNED_MODE ? prod_s : prod_u;
    assign limit_hi = SIGNED_MODE ? S_MAX : U_MAX;
    assign over = prod > limit_hi;
    assign under = SIGNED_MODE && (prod < S_MIN);
    assign clamped = over ? limit_hi : (under ? S_MIN : prod);
    assign shifted = clamped >>> LOW_POS;
    // unsigned results are never negative, so they always fill with zero
    assign fill = SIGNED_MODE ? shifted[SPAN-1] : 1'b0;
    assign field = (shifted[15:0] & LOW_MASK) | (fill ? ~LOW_MASK : `RESET_WORD);
endmodule : multiply_extract
`default_nettype wire

//--- verilog/saturating_math_blocks.sv
// Purpose: adder, accumulator, counter, shifter and multiplier blocks
// Assumes: step is a one-cycle pulse from the engine scheduler, same clock
// Notes: every result and every piece of state moves only on a step or on reset
`timescale 1ns/10ps
`default_nettype none
`include "math_cfg.svh"
module saturating_math_blocks #(
    parameter bit MUL_SIGNED = `MUL_SIGNED_DEFAULT,
    parameter math_pkg::bitpos_t MUL_HIGH = `MUL_HIGH_DEFAULT,
    parameter math_pkg::bitpos_t MUL_LOW = `MUL_LOW_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    input wire math_pkg::sword_t add_a,
    input wire math_pkg::sword_t add_b,
    output math_pkg::sword_t add_result,
    output logic overflow_flag,
    input wire math_pkg::sword_t acc_in,
    input wire logic acc_enable,
    input wire math_pkg::uword_t acc_preset,
    input wire math_pkg::bitpos_t extract_low_pos,
    input wire math_pkg::bitpos_t extract_high_pos,
    output math_pkg::uword_t acc_result,
    input wire math_pkg::sword_t cnt_in,
    input wire logic cnt_clear,
    input wire logic cnt_enable,
    output math_pkg::sword_t cnt_result,
    input wire math_pkg::sword_t shift_in,
    input wire math_pkg::exp_t shift_exponent,
    output math_pkg::sword_t shift_result,
    input wire math_pkg::sword_t operand_a,
    input wire math_pkg::sword_t operand_b,
    output math_pkg::uword_t mul_result
);
    import math_pkg::*;

    // returns {overflow, clamped sum}
    function automatic logic [16:0] sat_add(input sword_t a, input sword_t b);
        logic signed [16:0] wide;
        wide = 17'(a) + 17'(b);
        if (wide[16] == wide[15]) begin
            sat_add = {1'b0, wide[15:0]};
        end else if (wide[16]) begin
            sat_add = {1'b1, `NEG_LIMIT};
        end else begin
            sat_add = {1'b1, `POS_LIMIT};
        end
    endfunction : sat_add

    function automatic runsum_t widen(input sword_t v);
        widen = runsum_t'(32'(v));
    endfunction : widen

    // positions out of order give all 16 bits from the low position (zero if high is one below low); nothing guards them
    function automatic uword_t extract(input runsum_t v, input bitpos_t lo, input bitpos_t hi);
        logic [5:0] span;
        runsum_t moved;
        uword_t mask;
        span = 6'(hi) - 6'(lo) + `FIELD_ONE;
        moved = v >> lo;
        mask = (span >= `FIELD_FULL) ? 16'hffff : 16'((17'h1 << span) - 17'h1);
        extract = moved[15:0] & mask;
    endfunction : extract

    // adder
    wire logic [16:0] add_sat;
    assign add_sat = sat_add(add_a, add_b);

    always_ff @(posedge clk) begin
        if (rst) begin
            add_result <= `RESET_WORD;
            overflow_flag <= 1'b0;
        end else if (step) begin
            add_result <= add_sat[15:0];
            overflow_flag <= add_sat[16];
        end
    end

    // accumulator
    runsum_t acc_sum;
    wire runsum_t next_acc_sum;
    wire uword_t acc_frozen;
    wire uword_t acc_field;

    assign next_acc_sum = acc_sum + widen(acc_in);
    assign acc_frozen = acc_preset + uword_t'(acc_in);
    assign acc_field = extract(next_acc_sum, extract_low_pos, extract_high_pos);

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_sum <= `RESET_SUM;
            acc_result <= `RESET_WORD;
        end else if (step) begin
            if (acc_enable) begin
                acc_sum <= next_acc_sum;
                acc_result <= acc_field;
            end else begin
                acc_sum <= runsum_t'(acc_preset);
                acc_result <= acc_frozen;
            end
        end
    end

    // counter
    wire logic [16:0] cnt_sat;
    assign cnt_sat = sat_add(cnt_result, cnt_in);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_result <= `RESET_WORD;
        end else if (step) begin
            if (cnt_clear) begin
                cnt_result <= `RESET_WORD;
            end else if (cnt_enable) begin
                cnt_result <= cnt_sat[15:0];
            end
        end
    end

    // shifter: no overflow guard, the supplier keeps results in range
    wire logic [3:0] shift_left_amt;
    wire logic [3:0] shift_right_amt;
    wire sword_t shift_value;

    assign shift_left_amt = shift_exponent[3:0];
    assign shift_right_amt = 4'(-shift_exponent);
    assign shift_value = shift_exponent[4] ? (shift_in >>> shift_right_amt)
                                           : (shift_in <<< shift_left_amt);

    always_ff @(posedge clk) begin
        if (rst) begin
            shift_result <= `RESET_WORD;
        end else if (step) begin
            shift_result <= shift_value;
        end
    end

    // multiplier
    wire uword_t mul_field;

    multiply_extract #(
        .SIGNED_MODE(MUL_SIGNED),
        .HIGH_POS(MUL_HIGH),
        .LOW_POS(MUL_LOW)
    ) u_mul (
        .operand_a(operand_a),
        .operand_b(operand_b),
        .field(mul_field)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            mul_result <= `RESET_WORD;
        end else if (step) begin
            mul_result <= mul_field;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire logic signed [16:0] add_true;
    wire logic signed [16:0] cnt_true;
    wire logic [5:0] acc_span;
    assign add_true = 17'(add_a) + 17'(add_b);
    assign cnt_true = 17'(cnt_result) + 17'(cnt_in);
    assign acc_span = 6'(extract_high_pos) - 6'(extract_low_pos) + `FIELD_ONE;

    sequence count_step_s;
        step && !cnt_clear && cnt_enable;
    endsequence

    sequence top_held_s;
        count_step_s ##0 (cnt_result == `POS_LIMIT) && !cnt_in[15];
    endsequence

    sequence idle_s;
        !step;
    endsequence

    add_pos_sat_a: assert property (
        step && add_true > 17'sh0_7fff |=> add_result == `POS_LIMIT && overflow_flag
    ) else $error("adder positive clamp wrong");

    add_neg_sat_a: assert property (
        step && add_true < -17'sh0_8000 |=> add_result == `NEG_LIMIT && overflow_flag
    ) else $error("adder negative clamp wrong");

    add_plain_sum_a: assert property (
        step && add_true[16] == add_true[15] |=> !overflow_flag && add_result == $past(add_true[15:0])
    ) else $error("adder in-range sum wrong");

    acc_wrap_a: assert property (
        step && acc_enable |=> acc_sum == $past(acc_sum) + widen($past(acc_in))
    ) else $error("accumulator sum did not wrap-add");

    acc_freeze_a: assert property (
        step && !acc_enable |=> acc_result == $past(acc_frozen) && acc_sum == runsum_t'($past(acc_preset))
    ) else $error("accumulator freeze value wrong");

    acc_upper_zero_a: assert property (
        step && acc_enable && acc_span < `FIELD_FULL && extract_high_pos >= extract_low_pos
        |=> (acc_result >> $past(acc_span)) == `RESET_WORD
    ) else $error("accumulator upper bits not zero");

    cnt_clear_a: assert property (
        step && cnt_clear |=> cnt_result == `RESET_WORD
    ) else $error("counter clear ignored");

    cnt_hold_a: assert property (
        step && !cnt_clear && !cnt_enable |=> $stable(cnt_result)
    ) else $error("disabled counter moved");

    cnt_count_a: assert property (
        count_step_s ##0 cnt_true[16] == cnt_true[15] |=> cnt_result == $past(cnt_true[15:0])
    ) else $error("counter add wrong");

    cnt_no_wrap_a: assert property (
        top_held_s |=> cnt_result == `POS_LIMIT
    ) else $error("counter left positive limit");

    shift_sign_keep_a: assert property (
        step && shift_exponent[4] |=> shift_result[15] == $past(shift_in[15])
    ) else $error("right shift lost the sign");

    idle_hold_a: assert property (
        idle_s |=> $stable(add_result) && $stable(acc_sum) && $stable(acc_result)
            && $stable(cnt_result) && $stable(shift_result) && $stable(mul_result)
    ) else $error("output moved without a step");
endmodule : saturating_math_blocks
`default_nettype wire

//--- bench/sched_model.sv
// Purpose: engine scheduler model that issues execution steps
// Assumes: steps launch off the falling edge
// Notes: gap idles first, so slow schedules are seen too
`timescale 1ns/10ps
`default_nettype none
module sched_model (
    input wire logic clk,
    output logic step
);
    initial step = 1'b0;
    // one step per call, never held longer
    // a trailing idle cycle keeps two calls from touching step in one time step
    task fire(input int gap);
        repeat (gap) @(negedge clk);
        step = 1'b1;
        @(negedge clk);
        step = 1'b0;
        @(negedge clk);
    endtask : fire
endmodule : sched_model
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench of the saturating math blocks
// Assumes: default multiplier build 1, 14, 5
// Notes: a second top copy built unsigned covers unsigned multiplier mode
`timescale 1ns/10ps
`default_nettype none
module tb;
    import math_pkg::*;
    logic clk = 1'b0, rst = 1'b1, step, overflow_flag, acc_enable = 1'b0, cnt_clear = 1'b0, cnt_enable = 1'b0;
    sword_t add_a = '0, add_b = '0, acc_in = '0, cnt_in = '0, shift_in = '0, operand_a = '0, operand_b = '0;
    sword_t add_result, cnt_result, shift_result;
    uword_t acc_preset = '0, acc_result, mul_result, umul;
    bitpos_t extract_low_pos = '0, extract_high_pos = '0;
    exp_t shift_exponent = '0;
    int bad_count = 0, n_compared = 0, cycles = 0;
    always #5 clk = ~clk;
    sched_model sched_u (.clk, .step);
    // positions stay build constants in both copies
    saturating_math_blocks dut_u (.clk, .rst, .step, .add_a, .add_b, .add_result, .overflow_flag, .acc_in,
        .acc_enable, .acc_preset, .extract_low_pos, .extract_high_pos, .acc_result, .cnt_in, .cnt_clear,
        .cnt_enable, .cnt_result, .shift_in, .shift_exponent, .shift_result, .operand_a, .operand_b, .mul_result);
    saturating_math_blocks #(.MUL_SIGNED(1'b0)) dut2_u (.clk, .rst, .step, .add_a, .add_b, .add_result(),
        .overflow_flag(), .acc_in, .acc_enable, .acc_preset, .extract_low_pos, .extract_high_pos, .acc_result(),
        .cnt_in, .cnt_clear, .cnt_enable, .cnt_result(), .shift_in, .shift_exponent, .shift_result(),
        .operand_a, .operand_b, .mul_result(umul));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task summarize;
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task add_case(input sword_t a, input sword_t b, input sword_t r, input logic ov);
        add_a = a;
        add_b = b;
        sched_u.fire(0);
        check(add_result, r);
        check({15'h0, overflow_flag}, {15'h0, ov});
    endtask : add_case
    task t_add;
        add_case(16'sh7fff, 16'sh0001, 16'sh7fff, 1'b1);
        add_case(16'sh0064, 16'shffce, 16'sh0032, 1'b0);
        add_case(16'sh8000, 16'shffff, 16'sh8000, 1'b1);
        $display("adder test done");
    endtask : t_add
    task acc_step(input logic en, input sword_t a, input uword_t r);
        acc_enable = en;
        acc_in = a;
        sched_u.fire(1);
        check(acc_result, r);
    endtask : acc_step
    task t_acc;
        acc_preset = 16'h1234;
        extract_high_pos = 5'd15;
        acc_step(1'b0, 16'sh0001, 16'h1235);
        acc_step(1'b1, 16'shffff, 16'h1233);
        extract_low_pos = 5'd4;
        extract_high_pos = 5'd7;
        // narrow field: upper bits must read zero
        acc_step(1'b1, 16'shffff, 16'h0003);
        acc_preset = 16'h0000;
        acc_step(1'b0, 16'sh0000, 16'h0000);
        extract_low_pos = 5'd16;
        extract_high_pos = 5'd31;
        acc_step(1'b1, 16'shffff, 16'hffff);
        acc_step(1'b1, 16'sh0001, 16'h0000);
        $display("accumulator test done");
    endtask : t_acc
    task cnt_step(input logic clr, input logic en, input sword_t a, input sword_t r);
        cnt_clear = clr;
        cnt_enable = en;
        cnt_in = a;
        sched_u.fire(0);
        check(cnt_result, r);
    endtask : cnt_step
    task t_cnt;
        cnt_step(1'b0, 1'b1, 16'sh0005, 16'sh0005);
        cnt_step(1'b1, 1'b1, 16'sh0005, 16'sh0000);
        cnt_step(1'b0, 1'b1, 16'sh7ff0, 16'sh7ff0);
        cnt_step(1'b0, 1'b1, 16'sh0020, 16'sh7fff);
        cnt_step(1'b0, 1'b1, 16'sh0020, 16'sh7fff);
        cnt_step(1'b0, 1'b0, 16'shffff, 16'sh7fff);
        cnt_step(1'b0, 1'b1, 16'shffff, 16'sh7ffe);
        cnt_step(1'b0, 1'b1, 16'sh8000, 16'shfffe);
        cnt_step(1'b0, 1'b1, 16'sh8000, 16'sh8000);
        $display("counter test done");
    endtask : t_cnt
    // operands picked so the scaled value fits 16 bits
    task shift_case(input sword_t a, input exp_t e, input sword_t r);
        shift_in = a;
        shift_exponent = e;
        sched_u.fire(0);
        check(shift_result, r);
    endtask : shift_case
    task t_shift;
        shift_case(16'sh0001, 5'sh0e, 16'sh4000);
        shift_case(16'shfff0, 5'sh03, 16'shff80);
        shift_case(16'sh7000, 5'sh1c, 16'sh0700);
        shift_case(16'sh8000, 5'sh12, 16'shfffe);
        $display("shifter test done");
    endtask : t_shift
    task mul_case(input sword_t a, input sword_t b, input uword_t rs, input uword_t ru);
        operand_a = a;
        operand_b = b;
        sched_u.fire(0);
        check(mul_result, rs);
        check(umul, ru);
    endtask : mul_case
    task t_mul;
        mul_case(16'shffe0, 16'sh0003, 16'hfffd, 16'h03ff);
        mul_case(16'sh0111, 16'sh034c, 16'h01ff, 16'h03ff);
        mul_case(16'sh0c80, 16'sh0003, 16'h012c, 16'h012c);
        mul_case(16'shfeef, 16'sh034c, 16'hfe00, 16'h03ff);
        $display("multiplier test done");
    endtask : t_mul
    task t_hold;
        add_a = 16'sh0001;
        acc_in = 16'sh0100;
        cnt_in = 16'sh0001;
        shift_in = 16'sh0003;
        operand_a = 16'sh0001;
        repeat (3) @(negedge clk);
        check(add_result, 16'sh8000);
        check(acc_result, 16'h0000);
        check(cnt_result, 16'sh8000);
        check(shift_result, 16'shfffe);
        check(mul_result, 16'hfe00);
        $display("hold test done");
    endtask : t_hold
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        // first step only after an edge has seen reset low
        @(negedge clk);
        t_add();
        t_acc();
        t_cnt();
        t_shift();
        t_mul();
        t_hold();
        summarize();
    end
endmodule : tb
`default_nettype wire
